// ### src/irs_pkg.sv
package irs_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int IRS_LINES    = 16;
  localparam int IRS_EXT_PINS = 6;
  localparam int IRS_SOURCES  = 8;
  localparam int IRS_SEL_W    = 8;
  localparam int IRS_ADDR_W   = 16;
  localparam int IRS_DATA_W   = 8;
  localparam int IRS_LINE_W   = 4;
  localparam int IRS_SRC_W    = 3;

  // ****************************************************************
  // I/O map
  // ****************************************************************
  localparam logic [15:0] IRS_SEL_BASE_ADDR   = 16'hEFB0;
  localparam logic [15:0] IRS_LINE1_SEL_ADDR  = 16'hEFB1;
  localparam logic [15:0] IRS_LINE3_SEL_ADDR  = 16'hEFB3;
  localparam logic [15:0] IRS_REQ_LO_ADDR     = 16'hEFC0;
  localparam logic [15:0] IRS_REQ_HI_ADDR     = 16'hEFC1;
  localparam logic [15:0] IRS_PIN_STAT_ADDR   = 16'hEFC2;
  localparam logic [15:0] IRS_SHARED_LO_ADDR  = 16'hEFC3;
  localparam logic [15:0] IRS_SHARED_HI_ADDR  = 16'hEFC4;
  localparam logic [15:0] IRS_ROUTE_ERR_ADDR  = 16'hEFC5;
  localparam logic [7:0]  IRS_SEL_RESET       = 8'h00;
  localparam logic [7:0]  IRS_RDATA_UNMAPPED  = 8'h00;

  // ****************************************************************
  // Selection register fields
  // ****************************************************************
  localparam int IRS_SEL_HI_BIT  = 7;
  localparam int IRS_SEL_LO_BIT  = 6;
  localparam int IRS_SEL_EXT_MSB = 5;
  localparam int IRS_PIN_STAT_CARD_BIT = 7;

  // ****************************************************************
  // Fixed lines
  // ****************************************************************
  localparam int IRS_LINE_TIMER0  = 0;
  localparam int IRS_LINE_CASCADE = 2;
  localparam int IRS_LINE_RTC     = 8;
  localparam int IRS_CARD_PIN     = 5;
  localparam int IRS_MIN_PIN_LINES = 5;
  localparam logic [15:0] IRS_GP_MASK = 16'hFEFA;

  // ****************************************************************
  // Internal sources
  // ****************************************************************
  localparam logic [2:0] IRS_SRC_DMA    = 3'h0;
  localparam logic [2:0] IRS_SRC_PAR    = 3'h1;
  localparam logic [2:0] IRS_SRC_LCD    = 3'h2;
  localparam logic [2:0] IRS_SRC_CARD   = 3'h3;
  localparam logic [2:0] IRS_SRC_SERIAL = 3'h4;
  localparam logic [2:0] IRS_SRC_TIMER1 = 3'h5;
  localparam logic [2:0] IRS_SRC_SUP    = 3'h6;
  localparam logic [2:0] IRS_SRC_UART   = 3'h7;

  // Lines each source may reach, indexed by source code.
  localparam logic [7:0][15:0] IRS_ALLOWED = {
    16'h8418,   // uart
    16'h2862,   // supervisory timer
    16'h5048,   // timer one output
    16'h4A22,   // three-wire serial
    16'hDEB8,   // card interface
    16'h3290,   // lcd
    16'h6EA0,   // parallel port
    16'h8480    // dma chaining
  };

  // Source behind bit 7 and bit 6 of each line's register, line 15 first.
  localparam logic [15:0][2:0] IRS_HI_SRC = {
    3'h0, 3'h4, 3'h2, 3'h2, 3'h4, 3'h7, 3'h4, 3'h0,
    3'h0, 3'h6, 3'h6, 3'h7, 3'h7, 3'h0, 3'h6, 3'h0
  };
  localparam logic [15:0][2:0] IRS_LO_SRC = {
    3'h7, 3'h5, 3'h6, 3'h5, 3'h6, 3'h0, 3'h2, 3'h0,
    3'h2, 3'h5, 3'h4, 3'h2, 3'h5, 3'h0, 3'h4, 3'h0
  };

endpackage

// ### src/irs_sync2.sv
`timescale 1ns/100ps

module irs_sync2 #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ### src/irs_sel_reg.sv
`timescale 1ns/100ps

module irs_sel_reg #(
  parameter int         WIDTH = 8,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  always_comb begin
    value_next = wr_en ? wdata : value_reg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      value_reg <= RESET[WIDTH-1:0];
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

// ### src/irs_steering.sv
// How it works
// - Sixteen request lines are presented to the two cascaded interrupt controllers.
// - Line 0 carries timer zero tick, line 2 is cascade, line 8 the clock alarm.
// - Lines 1, 3 to 7 and 9 to 15 are general purpose, steerable lines.
// - With the card interface enabled, external pin 5 becomes the card request.
// - Each of six external pins can be steered onto any general purpose line.
// - DMA, parallel port, LCD and UART reach only their permitted line sets.
// - Card, three-wire, timer one and supervisory timer reach only permitted lines.
// - Eight distinct internal sources still leave five general lines for pins.
// - Every selection register is eight bits and resets to zero, driving nothing.
// - A one bit connects its source to the line; a zero disconnects it.
// - Several bits may be set so level sources share one line.
// - Line 1 register at EFB1: bit7 supervisory, bit6 three-wire, bits5-0 pins.
// - Line 3 register at EFB3: bit7 UART, bit6 timer one, bits5-0 pins.
// - Line 3 may also be driven by the card request under its own configuration.
`timescale 1ns/100ps

module irs_steering
  import irs_pkg::*;
#(
  parameter int LINES    = irs_pkg::IRS_LINES,
  parameter int EXT_PINS = irs_pkg::IRS_EXT_PINS
) (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire logic [irs_pkg::IRS_ADDR_W-1:0] io_addr,
  input  wire logic [irs_pkg::IRS_DATA_W-1:0] io_wdata,
  input  wire logic                          io_wr,
  input  wire logic                          io_rd,
  output logic      [irs_pkg::IRS_DATA_W-1:0] io_rdata,
  output logic                               io_rd_valid,
  input  wire logic [irs_pkg::IRS_EXT_PINS-1:0] external_request_pins,
  input  wire logic                          card_enable,
  input  wire logic [irs_pkg::IRS_LINE_W-1:0] card_route_line,
  input  wire logic                          parallel_request,
  input  wire logic [irs_pkg::IRS_LINE_W-1:0] parallel_route_line,
  input  wire logic                          dma_chain_request,
  input  wire logic                          lcd_request,
  input  wire logic                          uart_request,
  input  wire logic                          serial_request,
  input  wire logic                          timer_one_output,
  input  wire logic                          supervisory_request,
  input  wire logic                          timer_zero_output,
  input  wire logic                          rtc_request,
  output logic      [irs_pkg::IRS_LINES-1:0] pic_request
);

  import irs_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The routing tables are sized for exactly sixteen lines and six pins.
  if (LINES != IRS_LINES || EXT_PINS != IRS_EXT_PINS) begin : g_bad_size
    $error("irs_steering supports only sixteen lines and six external pins");
  end

  // Selection writes pass io_wdata straight into a register, so the widths must agree.
  if (IRS_SEL_W != IRS_DATA_W) begin : g_bad_sel_width
    $error("irs_steering needs selection registers as wide as the data bus");
  end

  // Bits five to zero map one to one onto the pins, below the two source bits.
  if (IRS_SEL_EXT_MSB + 1 != EXT_PINS || IRS_SEL_LO_BIT <= IRS_SEL_EXT_MSB) begin : g_bad_field
    $error("irs_steering pin field does not fit the selection register");
  end

  // With every source on a line of its own, enough lines must stay free for the pins.
  if ($countones(IRS_GP_MASK) < IRS_SOURCES + IRS_MIN_PIN_LINES) begin : g_bad_spare
    $error("irs_steering leaves too few general lines for the pins");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic src_may_reach(input logic [2:0] src, input int line);
    src_may_reach = IRS_ALLOWED[src][line];
  endfunction

  // Route zero means unused; line zero is fixed, so it can never match.
  function automatic logic route_hits(input logic [3:0] route, input logic [2:0] src,
                                      input int line);
    route_hits = (route == line[3:0]) && src_may_reach(src, line) && IRS_GP_MASK[line];
  endfunction

  // At most ten drivers: six pins, two register sources and two routed ports.
  function automatic logic [3:0] count_ones(input logic [9:0] vec);
    logic [3:0] acc;
    acc = 4'h0;
    for (int i = 0; i < 10; i++) begin
      acc = acc + {3'h0, vec[i]};
    end
    count_ones = acc;
  endfunction

  function automatic logic route_bad(input logic [3:0] route, input logic [2:0] src);
    route_bad = (route != 4'h0) && !IRS_ALLOWED[src][route];
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  // Pins reach the lines three edges after they move: two sync stages and the output flop.
  logic [IRS_EXT_PINS-1:0] pins_sync;

  irs_sync2 #(
    .WIDTH (IRS_EXT_PINS)
  ) u_pin_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (external_request_pins),
    .sync_out (pins_sync)
  );

  // ****************************************************************
  // Selection registers
  // ****************************************************************
  logic [IRS_LINES-1:0]                sel_wr;
  logic [IRS_LINES-1:0][IRS_SEL_W-1:0] sel_value;
  logic                                sel_window;
  logic [3:0]                          sel_index;

  always_comb begin
    sel_window = (io_addr[15:4] == IRS_SEL_BASE_ADDR[15:4]);
    sel_index  = io_addr[3:0];
    sel_wr     = '0;
    if (io_wr && sel_window && IRS_GP_MASK[sel_index]) begin
      sel_wr[sel_index] = 1'b1;
    end
  end

  // Fixed lines get no register, so writes to their slots are dropped silently.
  for (genvar g = 0; g < IRS_LINES; g++) begin : g_sel
    if (IRS_GP_MASK[g]) begin : g_gp
      irs_sel_reg #(
        .WIDTH (IRS_SEL_W),
        .RESET (IRS_SEL_RESET)
      ) u_sel (
        .clock (clock),
        .rstn  (rstn),
        .wr_en (sel_wr[g]),
        .wdata (io_wdata),
        .value (sel_value[g])
      );
    end else begin : g_fixed
      assign sel_value[g] = IRS_SEL_RESET;
    end
  end

  // ****************************************************************
  // Source gathering
  // ****************************************************************
  // Internal sources already run on this clock, so they need no synchroniser.
  logic [IRS_SOURCES-1:0]  src_level;
  logic [IRS_EXT_PINS-1:0] pins_general;

  always_comb begin
    src_level = '0;
    src_level[IRS_SRC_DMA]    = dma_chain_request;
    src_level[IRS_SRC_PAR]    = parallel_request;
    src_level[IRS_SRC_LCD]    = lcd_request;
    src_level[IRS_SRC_CARD]   = card_enable & pins_sync[IRS_CARD_PIN];
    src_level[IRS_SRC_SERIAL] = serial_request;
    src_level[IRS_SRC_TIMER1] = timer_one_output;
    src_level[IRS_SRC_SUP]    = supervisory_request;
    src_level[IRS_SRC_UART]   = uart_request;
    pins_general = pins_sync;
    // A card-owned pin must not also appear as a general request.
    pins_general[IRS_CARD_PIN] = pins_sync[IRS_CARD_PIN] & ~card_enable;
  end

  // ****************************************************************
  // Steering
  // ****************************************************************
  // Registered lines keep decode glitches away from edge-sensitive controller inputs.
  logic [IRS_LINES-1:0] req_reg;
  logic [IRS_LINES-1:0] req_next;
  logic [IRS_LINES-1:0] shared_reg;
  logic [IRS_LINES-1:0] shared_next;
  logic [1:0]           route_err_reg;
  logic [1:0]           route_err_next;

  always_comb begin
    logic [2:0] hi_src;
    logic [2:0] lo_src;
    logic [9:0] drivers;
    hi_src   = 3'h0;
    lo_src   = 3'h0;
    drivers  = '0;
    req_next = '0;
    shared_next = '0;
    for (int l = 0; l < IRS_LINES; l++) begin
      hi_src  = IRS_HI_SRC[l];
      lo_src  = IRS_LO_SRC[l];
      drivers = '0;
      if (IRS_GP_MASK[l]) begin
        drivers[5:0] = sel_value[l][IRS_SEL_EXT_MSB:0] & pins_general;
        drivers[6]   = sel_value[l][IRS_SEL_LO_BIT] & src_level[lo_src]
                       & src_may_reach(lo_src, l);
        drivers[7]   = sel_value[l][IRS_SEL_HI_BIT] & src_level[hi_src]
                       & src_may_reach(hi_src, l);
        drivers[8]   = src_level[IRS_SRC_CARD]
                       & route_hits(card_route_line, IRS_SRC_CARD, l);
        drivers[9]   = src_level[IRS_SRC_PAR]
                       & route_hits(parallel_route_line, IRS_SRC_PAR, l);
        req_next[l]  = |drivers;
        // Counting drivers lets software spot two edge sources on one line.
        shared_next[l] = (count_ones(drivers) > 4'h1);
      end
    end
    // Fixed lines bypass the steering entirely.
    req_next[IRS_LINE_TIMER0]  = timer_zero_output;
    req_next[IRS_LINE_CASCADE] = 1'b0;
    req_next[IRS_LINE_RTC]     = rtc_request;
    // A route outside its permitted set never drives; software can read the flag.
    route_err_next = {route_bad(parallel_route_line, IRS_SRC_PAR),
                      route_bad(card_route_line, IRS_SRC_CARD)};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_reg       <= '0;
      shared_reg    <= '0;
      route_err_reg <= '0;
    end else begin
      req_reg       <= req_next;
      shared_reg    <= shared_next;
      route_err_reg <= route_err_next;
    end
  end

  // Lines change only on a clock edge, one cycle after internal sources and three edges after the pins.
  assign pic_request = req_reg;

  // ****************************************************************
  // Register read
  // ****************************************************************
  // The sharing flags only report; edge-mode conflicts are software's to avoid.
  // A read in the same cycle as a write returns the old register value.
  // Unmapped reads answer zero with no valid, so a stray read cannot pass for data.
  logic [IRS_DATA_W-1:0] rdata_reg;
  logic [IRS_DATA_W-1:0] rdata_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;

  always_comb begin
    rdata_next  = IRS_RDATA_UNMAPPED;
    rvalid_next = 1'b0;
    if (io_rd) begin
      if (sel_window && IRS_GP_MASK[sel_index]) begin
        rdata_next  = sel_value[sel_index];
        rvalid_next = 1'b1;
      end else begin
        case (io_addr)
          IRS_REQ_LO_ADDR: begin
            rdata_next  = req_reg[7:0];
            rvalid_next = 1'b1;
          end
          IRS_REQ_HI_ADDR: begin
            rdata_next  = req_reg[15:8];
            rvalid_next = 1'b1;
          end
          IRS_PIN_STAT_ADDR: begin
            rdata_next = {card_enable, 1'b0, pins_sync};
            rvalid_next = 1'b1;
          end
          IRS_SHARED_LO_ADDR: begin
            rdata_next  = shared_reg[7:0];
            rvalid_next = 1'b1;
          end
          IRS_SHARED_HI_ADDR: begin
            rdata_next  = shared_reg[15:8];
            rvalid_next = 1'b1;
          end
          IRS_ROUTE_ERR_ADDR: begin
            rdata_next  = {6'h00, route_err_reg};
            rvalid_next = 1'b1;
          end
          default: begin
            rdata_next  = IRS_RDATA_UNMAPPED;
            rvalid_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_reg  <= IRS_RDATA_UNMAPPED;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign io_rdata    = rdata_reg;
  assign io_rd_valid = rvalid_reg;

endmodule

// ### testbench/irs_steering_assertions.sv
`timescale 1ns/100ps

module irs_steering_assertions
  import irs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rd_valid,
  input wire logic [5:0]  external_request_pins,
  input wire logic        card_enable,
  input wire logic [3:0]  card_route_line,
  input wire logic        parallel_request,
  input wire logic [3:0]  parallel_route_line,
  input wire logic        timer_zero_output,
  input wire logic        rtc_request,
  input wire logic [15:0] pic_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_cascade_line_low: assert property (pic_request[2] == 1'b0)
    else $error("cascade line driven");
  a_timer_zero_line: assert property (1 |=> pic_request[0] == $past(timer_zero_output))
    else $error("line 0 does not follow timer zero");
  a_rtc_line_high: assert property (rtc_request |=> pic_request[8])
    else $error("line 8 missed clock request");
  a_line3_read_valid: assert property (io_rd && io_addr == IRS_LINE3_SEL_ADDR |=> io_rd_valid)
    else $error("line 3 read gave no valid");
  a_no_reg_line0: assert property (io_rd && io_addr == IRS_SEL_BASE_ADDR |=>
    !io_rd_valid && io_rdata == 8'h00) else $error("line 0 read answered");
  a_idle_rdata_zero: assert property (!io_rd |=> !io_rd_valid && io_rdata == 8'h00)
    else $error("read data without read");
  a_line1_write_read: assert property (io_wr && io_addr == IRS_LINE1_SEL_ADDR ##1
    io_rd && !io_wr && io_addr == IRS_LINE1_SEL_ADDR |=>
    io_rd_valid && io_rdata == $past(io_wdata, 2)) else $error("line 1 readback wrong");
  a_parallel_route: assert property (parallel_request && parallel_route_line == 4'd13
    |=> pic_request[13]) else $error("parallel request lost on line 13");
  a_card_route_line3: assert property ((card_enable && external_request_pins[5]
    && card_route_line == 4'd3)[*4] |=> pic_request[3]) else $error("card request lost");
endmodule

bind irs_steering irs_steering_assertions u_chk (
  .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
  .io_rd(io_rd), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
  .external_request_pins(external_request_pins), .card_enable(card_enable),
  .card_route_line(card_route_line), .parallel_request(parallel_request),
  .parallel_route_line(parallel_route_line), .timer_zero_output(timer_zero_output),
  .rtc_request(rtc_request), .pic_request(pic_request)
);

// ### testbench/irs_pic_pair_model.sv
`timescale 1ns/100ps

module irs_pic_pair_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        init_done,
  input  wire logic [15:0] pic_request,
  output logic      [7:0]  master_seen,
  output logic      [7:0]  slave_seen
);
  logic [15:0] seen_reg;
  logic [15:0] seen_next;

  // Level sampling lets shared lines work; nothing counts before set-up.
  always_comb begin
    seen_next = init_done ? pic_request : 16'h0000;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seen_reg <= 16'h0000;
    end else begin
      seen_reg <= seen_next;
    end
  end

  assign master_seen = seen_reg[7:0];
  assign slave_seen  = seen_reg[15:8];
endmodule

// ### testbench/irs_steering_tb.sv
`timescale 1ns/100ps

module irs_steering_tb;
  import irs_pkg::*;
  logic        clock, rstn, io_wr, io_rd, io_rd_valid, card_enable, tz, rtc, init_done;
  logic [15:0] io_addr, pic_request;
  logic [7:0]  io_wdata, io_rdata, s1, s3, master_seen, slave_seen;
  logic [5:0]  pins;
  logic [6:0]  src;
  logic [3:0]  card_route_line, parallel_route_line;
  logic [31:0] r;
  logic [15:0] tbl [5];
  int          n_fail, checks;

  irs_steering dut (
    .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .external_request_pins(pins), .card_enable(card_enable),
    .card_route_line(card_route_line), .parallel_request(src[1]),
    .parallel_route_line(parallel_route_line), .dma_chain_request(src[0]),
    .lcd_request(src[2]), .uart_request(src[6]), .serial_request(src[3]),
    .timer_one_output(src[4]), .supervisory_request(src[5]),
    .timer_zero_output(tz), .rtc_request(rtc), .pic_request(pic_request)
  );

  irs_pic_pair_model u_pic (
    .clock(clock), .rstn(rstn), .init_done(init_done), .pic_request(pic_request),
    .master_seen(master_seen), .slave_seen(slave_seen)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************************************
  // Expected line levels
  // ****************************************************************
  function automatic logic [15:0] exp_lines(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] e;
    logic [5:0]  p;
    e = 16'h0000;
    p = pins & ~{card_enable, 5'b0_0000};
    e[0] = tz;
    e[8] = rtc;
    e[1] = |(a[5:0] & p) | (a[7] & src[5]) | (a[6] & src[3]);
    e[3] = |(b[5:0] & p) | (b[7] & src[6]) | (b[6] & src[4]);
    if (IRS_ALLOWED[3][card_route_line]) e[card_route_line] |= card_enable & pins[5];
    if (IRS_ALLOWED[1][parallel_route_line]) e[parallel_route_line] |= src[1];
    return e;
  endfunction

  // Status byte k of the read-only block: lines, pins, sharing flags, route faults.
  function automatic logic [7:0] exp_status(input int k, input logic [7:0] a,
                                            input logic [7:0] b);
    logic [15:0] e;
    logic [15:0] sh;
    logic [5:0]  p;
    int          n [16];
    e = exp_lines(a, b);
    p = pins & ~{card_enable, 5'b0_0000};
    n = '{default: 0};
    n[1] = $countones({a[5:0] & p, a[7] & src[5], a[6] & src[3]});
    n[3] = $countones({b[5:0] & p, b[7] & src[6], b[6] & src[4]});
    if (IRS_ALLOWED[3][card_route_line]) n[card_route_line] += int'(card_enable & pins[5]);
    if (IRS_ALLOWED[1][parallel_route_line]) n[parallel_route_line] += int'(src[1]);
    for (int l = 0; l < 16; l++) sh[l] = (n[l] > 1);
    case (k)
      0: return e[7:0];
      1: return e[15:8];
      2: return {card_enable, 1'b0, pins};
      3: return sh[7:0];
      4: return sh[15:8];
      default: return {6'h00,
                       (parallel_route_line != 4'h0 && !IRS_ALLOWED[1][parallel_route_line]),
                       (card_route_line != 4'h0 && !IRS_ALLOWED[3][card_route_line])};
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [8:0] exp, input string what);
    checks++;
    if ({io_rd_valid, io_rdata} !== exp) begin
      n_fail++;
      $display("Error %0t: %s read %h expected %h", $time, what, {io_rd_valid, io_rdata}, exp);
    end
  endtask

  // One bus cycle; strobes stay as set until the next call changes them.
  task automatic acc(input logic w, input logic rd, input logic [15:0] a, input logic [7:0] d);
    io_wr = w;
    io_rd = rd;
    io_addr = a;
    io_wdata = d;
    @(posedge clock);
    #1;
  endtask

  task automatic do_reset;
    rstn = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
  endtask

  task automatic stop_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test;
  end

  initial begin
    {io_wr, io_rd, io_addr, io_wdata, pins, src, card_enable} = '0;
    {card_route_line, parallel_route_line, tz, rtc, init_done, s1, s3} = '0;
    rstn = 1'b0;
    n_fail = 0;
    checks = 0;
    tbl = '{IRS_LINE1_SEL_ADDR, IRS_LINE3_SEL_ADDR, IRS_SEL_BASE_ADDR, 16'hEFB2, 16'hEFB8};
    r = $urandom(32'hcdb9dc5d);
    do_reset;
    init_done = 1'b1;
    chk(pic_request, 16'h0000, "lines after reset");
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, 1'b1, tbl[i], 8'h00);
      chk_rd(9'h100, "reset value");
    end
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b0, tbl[i], 8'hFF);
      acc(1'b0, 1'b1, tbl[i], 8'h00);
      chk_rd((i < 2) ? 9'h1FF : 9'h000, "map");
    end
    for (int i = 0; i < 60; i++) begin
      r = $urandom;
      {s1, s3} = r[15:0];
      if (i < 8) begin
        s1 = 8'h01 << i;
        s3 = 8'h80 >> i;
      end
      acc(1'b1, 1'b0, IRS_LINE1_SEL_ADDR, s1);
      acc(1'b1, 1'b0, IRS_LINE3_SEL_ADDR, s3);
      r = $urandom;
      {pins, src, card_enable, card_route_line, parallel_route_line, tz, rtc} = r[23:0];
      if (i % 4 == 0) card_route_line = 4'd3;
      if (i % 4 == 1) parallel_route_line = 4'd13;
      repeat (5) acc(1'b0, 1'b0, 16'h0000, 8'h00);
      chk({slave_seen, master_seen}, exp_lines(s1, s3), "lines");
      acc(1'b0, 1'b1, IRS_LINE3_SEL_ADDR, 8'h00);
      chk_rd({1'b1, s3}, "line 3 select");
      for (int k = 0; k < 6; k++) begin
        acc(1'b0, 1'b1, IRS_REQ_LO_ADDR + 16'(k), 8'h00);
        chk_rd({1'b1, exp_status(k, s1, s3)}, "status");
      end
    end
    acc(1'b0, 1'b0, 16'h0000, 8'h00);
    do_reset;
    acc(1'b0, 1'b1, IRS_LINE1_SEL_ADDR, 8'h00);
    chk_rd(9'h100, "select after reset");
    repeat (5) acc(1'b0, 1'b0, 16'h0000, 8'h00);
    chk({slave_seen, master_seen}, exp_lines(8'h00, 8'h00), "lines after reset");
    stop_test;
  end
endmodule
